//--- hdl/operand_address_generator.sv
// How it works
// RQ1: multiply A by X, product into accumulator pair
// RQ2: bank flags plus select code pick register
// RQ3: three bit code picks one byte register
// RQ4: fixed code order for bytes and pairs
// RQ5: direct mode uses 16-bit immediate unchanged
// RQ6: short direct reaches only FE20H to FF1FH
// RQ7: bit 8 set below 20H, top bits ones
// RQ8: 16-bit short direct needs even address
// RQ9: sfr address FF00H plus byte, gap refused
// RQ10: 16-bit sfr needs even, capable register
// RQ11: indirect uses whole pointer or base pair
// RQ12: based adds zero-extended byte to base pair
// RQ13: based indexed adds B or C to base
// RQ14: stack mode addresses through stack pointer
// RQ15: stack reaches internal high-speed RAM only
// RQ16: FE20H-FEFFH is RAM, FF00H-FF1FH is sfr
// RQ17: two bank flags index four register banks
module operand_address_generator
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire addr_gen_pkg::request_type req,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [15:0] stack_ptr,
  input wire logic reg_wr_en,
  input wire logic reg_wr_wide,
  input wire logic [2:0] reg_wr_code,
  input wire logic [15:0] reg_wr_data,
  output logic ans_valid,
  output addr_gen_pkg::result_type ans
);

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [7:0] byte_of(input logic [63:0] row, input logic [2:0] code);
    byte_of = row[code*8 +: 8];
  endfunction

  function automatic logic [15:0] pair_of(input logic [63:0] row, input logic [1:0] pc);
    pair_of = {byte_of(row, {pc, 1'b1}), byte_of(row, {pc, 1'b0})};
  endfunction

  function automatic addr_gen_pkg::area_type area_of(input logic [15:0] addr);
    if (addr >= addr_gen_pkg::HS_RAM_LO && addr <= addr_gen_pkg::HS_RAM_HI)
      area_of = addr_gen_pkg::area_hs_ram;
    else if (addr >= addr_gen_pkg::SFR_BASE)
      area_of = addr_gen_pkg::area_sfr;
    else
      area_of = addr_gen_pkg::area_other;
  endfunction

  // ********************************************************
  // stage one: request held while the bank is read
  // ********************************************************
  logic [1:0] bank_now;
  logic s1_valid;
  addr_gen_pkg::request_type s1_req;
  logic [1:0] s1_bank;
  logic [15:0] s1_sp;
  logic [63:0] row;
  logic mem_wr_en;
  logic mem_wr_wide;
  logic [4:0] mem_wr_index;
  logic [15:0] mem_wr_data;
  logic [7:0] a_val;
  logic [7:0] x_val;
  logic [15:0] base_pair_val;
  logic [15:0] product;
  logic is_mul;
  addr_gen_pkg::result_type next_ans;

  // both flags together form the bank number
  assign bank_now = {bank_select_high, bank_select_low}; // RQ17 RQ2

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      s1_valid <= 1'b0;
    else
      s1_valid <= req_valid;
  end

  // request fields need no reset, valid guards them
  always_ff @(posedge ref_clk)
  begin
    s1_req <= req;
    s1_bank <= bank_now;
    s1_sp <= stack_ptr;
  end

  reg_bank_mem u_regs
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wr_en(mem_wr_en),
    .wr_wide(mem_wr_wide),
    .wr_index(mem_wr_index),
    .wr_data(mem_wr_data),
    .rd_bank(bank_now),
    .rd_row(row)
  );

  // ********************************************************
  // operands out of the active bank
  // ********************************************************
  assign a_val = byte_of(row, addr_gen_pkg::CODE_A);
  assign x_val = byte_of(row, addr_gen_pkg::CODE_X);
  assign base_pair_val = pair_of(row, addr_gen_pkg::BASE_PAIR);
  assign product = {8'h00, a_val} * {8'h00, x_val}; // RQ1
  assign is_mul = s1_valid && s1_req.mode == addr_gen_pkg::mode_implied_mul;

  // multiply result wins the write port; a core write in that cycle is lost
  always_comb
  begin
    if (is_mul)
    begin
      mem_wr_en = 1'b1; // RQ1
      mem_wr_wide = 1'b1;
      mem_wr_index = {s1_bank, addr_gen_pkg::ACC_PAIR, 1'b0};
      mem_wr_data = product;
    end
    else
    begin
      mem_wr_en = reg_wr_en;
      mem_wr_wide = reg_wr_wide;
      mem_wr_index = {bank_now, reg_wr_code};
      mem_wr_data = reg_wr_data;
    end
  end

  // ********************************************************
  // effective address per mode
  // ********************************************************
  always_comb
  begin
    next_ans = addr_gen_pkg::RESULT_RESET;
    case (s1_req.mode)
      addr_gen_pkg::mode_implied_mul:
      begin
        next_ans.reg_index = {s1_bank, addr_gen_pkg::ACC_PAIR, 1'b0}; // RQ1
        next_ans.operand = product;
      end
      addr_gen_pkg::mode_reg8:
      begin
        next_ans.reg_index = {s1_bank, s1_req.byte_reg_select_code}; // RQ3 RQ4
        next_ans.operand = {8'h00, byte_of(row, s1_req.byte_reg_select_code)};
      end
      addr_gen_pkg::mode_reg16:
      begin
        next_ans.reg_index = {s1_bank, s1_req.pair_select_code, 1'b0}; // RQ4 RQ2
        next_ans.operand = pair_of(row, s1_req.pair_select_code);
      end
      addr_gen_pkg::mode_direct:
        next_ans.eff_addr = s1_req.imm16; // RQ5
      addr_gen_pkg::mode_short:
      begin
        // window is fixed, so no byte value can leave it
        next_ans.eff_addr = {addr_gen_pkg::SHORT_TOP_BITS, s1_req.imm8 < addr_gen_pkg::SHORT_SFR_LIMIT,
                             s1_req.imm8}; // RQ6 RQ7
        next_ans.fault = s1_req.wide && s1_req.imm8[0]; // RQ8
      end
      addr_gen_pkg::mode_sfr:
      begin
        next_ans.eff_addr = addr_gen_pkg::SFR_BASE + {8'h00, s1_req.imm8}; // RQ9
        next_ans.fault = (next_ans.eff_addr >= addr_gen_pkg::SFR_GAP_LO
                          && next_ans.eff_addr <= addr_gen_pkg::SFR_GAP_HI)
                         || (s1_req.wide && (s1_req.imm8[0] || !s1_req.sfr_wide_ok)); // RQ9 RQ10
      end
      addr_gen_pkg::mode_indirect:
      begin
        next_ans.eff_addr = pair_of(row, s1_req.pair_select_code); // RQ11
        next_ans.fault = s1_req.pair_select_code != addr_gen_pkg::POINTER_PAIR_TWO
                         && s1_req.pair_select_code != addr_gen_pkg::BASE_PAIR;
      end
      addr_gen_pkg::mode_based:
        next_ans.eff_addr = base_pair_val + {8'h00, s1_req.imm8}; // RQ12
      addr_gen_pkg::mode_based_idx:
        next_ans.eff_addr = base_pair_val + {8'h00, s1_req.index_is_b ? byte_of(row, addr_gen_pkg::CODE_B)
                                                               : byte_of(row, addr_gen_pkg::CODE_C)}; // RQ13
      addr_gen_pkg::mode_stack:
      begin
        next_ans.eff_addr = s1_sp; // RQ14
        next_ans.fault = area_of(s1_sp) != addr_gen_pkg::area_hs_ram; // RQ15
      end
      default:
        next_ans.fault = 1'b1;
    endcase
    // memory modes name an area; register modes leave it none
    if (s1_req.mode != addr_gen_pkg::mode_implied_mul && s1_req.mode != addr_gen_pkg::mode_reg8
        && s1_req.mode != addr_gen_pkg::mode_reg16)
      next_ans.area = area_of(next_ans.eff_addr); // RQ16
  end

  // ********************************************************
  // answer register
  // ********************************************************
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ans_valid <= 1'b0;
      ans <= addr_gen_pkg::RESULT_RESET;
    end
    else
    begin
      ans_valid <= s1_valid;
      if (s1_valid)
        ans <= next_ans;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic [15:0] sp_hist;
  always_ff @(posedge ref_clk)
    sp_hist <= s1_sp;

  chk_mul_product: assert property (is_mul |=> ans.operand == {8'h00, $past(row[15:8])} * {8'h00, $past(row[7:0])}
                                    && $past(mem_wr_data) == ans.operand) // RQ1
    else $error("multiply product wrong");
  chk_mul_index: assert property (is_mul |=> ans.reg_index == {$past(s1_bank), 3'h0}) // RQ1
    else $error("product register index wrong");
  chk_mul_writes_ax: assert property (is_mul |-> mem_wr_en && mem_wr_wide && mem_wr_index[2:0] == 3'h0) // RQ1
    else $error("product not written to the accumulator pair");
  chk_bank_from_flags: assert property (req_valid && req.mode == addr_gen_pkg::mode_reg8
                                        |-> ##2 ans.reg_index[4:3] == $past(bank_now, 2)) // RQ17 RQ2
    else $error("register bank not taken from flags");
  chk_byte_reg_code: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_reg8
                                      |=> ans.reg_index[2:0] == $past(s1_req.byte_reg_select_code)
                                      && ans.operand[7:0] == $past(row[s1_req.byte_reg_select_code*8 +: 8])) // RQ3
    else $error("byte register code misdecoded");
  chk_pair_order: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_reg16
                                   |=> ans.operand == $past({row[s1_req.pair_select_code*16+8 +: 8],
                                                             row[s1_req.pair_select_code*16 +: 8]})) // RQ4
    else $error("pair code misdecoded");
  chk_direct_addr: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_direct
                                    |=> ans.eff_addr == $past(s1_req.imm16) && !ans.fault) // RQ5
    else $error("direct address altered");
  chk_short_window: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_short
                                     |=> ans.eff_addr >= 16'hfe20 && ans.eff_addr <= 16'hff1f
                                     && ans.eff_addr[8] == ($past(s1_req.imm8) < 8'h20)) // RQ6 RQ7
    else $error("short direct address outside window");
  chk_short_even: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_short && s1_req.wide
                                   && s1_req.imm8[0] |=> ans_valid && ans.fault) // RQ8
    else $error("odd 16-bit short direct not refused");
  chk_sfr_range: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_sfr && !s1_req.wide
                                  |=> ans.fault == (ans.eff_addr[7:4] == 4'hd)
                                  && ans.eff_addr == {8'hff, $past(s1_req.imm8)}) // RQ9
    else $error("sfr address or gap wrong");
  chk_sfr_wide: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_sfr && s1_req.wide
                                 && !s1_req.sfr_wide_ok |=> ans.fault) // RQ10
    else $error("16-bit sfr on byte-only register not refused");
  chk_indirect_pair: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_indirect
                                      && s1_req.pair_select_code == addr_gen_pkg::POINTER_PAIR_TWO
                                      |=> ans.eff_addr == $past(row[47:32]) && !ans.fault) // RQ11
    else $error("indirect address not the pair");
  chk_based_wrap: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_based
                                   |=> ans.eff_addr == 16'($past(row[63:48]) + $past(s1_req.imm8))) // RQ12
    else $error("based address wrong");
  chk_based_index: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_based_idx && s1_req.index_is_b
                                    |=> ans.eff_addr == 16'($past(row[63:48]) + $past(row[31:24]))) // RQ13
    else $error("based indexed address wrong");
  chk_stack_ram: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_stack
                                  |=> ans.eff_addr == sp_hist
                                  && ans.fault == !(sp_hist >= 16'hfe20 && sp_hist <= 16'hfeff)) // RQ14 RQ15
    else $error("stack address or confinement wrong");
  chk_area_decode: assert property (ans_valid && ans.area != addr_gen_pkg::area_none
                                    && ans.eff_addr >= 16'hfe20 && ans.eff_addr <= 16'hff1f
                                    |-> ans.area == (ans.eff_addr[8] ? addr_gen_pkg::area_sfr
                                                                     : addr_gen_pkg::area_hs_ram)) // RQ16
    else $error("window area misdecoded");
  chk_answer_latency: assert property (req_valid |-> ##2 ans_valid)
    else $error("answer not two cycles after request");

  // cases that the first set of checks leaves open
  chk_indirect_base: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_indirect
                                      && s1_req.pair_select_code == 2'h3
                                      |=> ans.eff_addr == $past(row[63:48]) && !ans.fault) // RQ11
    else $error("indirect address not the base pair");
  chk_indirect_refuse: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_indirect
                                        && !s1_req.pair_select_code[1] |=> ans.fault) // RQ11
    else $error("indirect through a non-pointer pair not refused");
  chk_based_c_index: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_based_idx && !s1_req.index_is_b
                                      |=> ans.eff_addr == 16'($past(row[63:48]) + $past(row[23:16]))) // RQ13
    else $error("based indexed address with C wrong");
  chk_sfr_odd_wide: assert property (s1_valid && s1_req.mode == addr_gen_pkg::mode_sfr && s1_req.wide
                                     && s1_req.imm8[0] |=> ans.fault) // RQ10
    else $error("odd 16-bit sfr not refused");
  chk_reg_no_area: assert property (s1_valid && (s1_req.mode == addr_gen_pkg::mode_reg8
                                    || s1_req.mode == addr_gen_pkg::mode_reg16)
                                    |=> ans.area == addr_gen_pkg::area_none && ans.eff_addr == 16'h0000) // RQ2
    else $error("register operand given a memory area");

  cov_multiply: cover property (is_mul ##1 ans_valid);
  cov_short_sfr: cover property (s1_valid && s1_req.mode == addr_gen_pkg::mode_short && s1_req.imm8 < 8'h20);
  cov_stack_fault: cover property (ans_valid && ans.fault && ans.eff_addr < 16'hfe20);
  cov_based_wrap: cover property (s1_valid && s1_req.mode == addr_gen_pkg::mode_based
                                  && next_ans.eff_addr < base_pair_val);
  cov_other_bank: cover property (s1_valid && s1_req.mode == addr_gen_pkg::mode_reg8 && s1_bank == 2'h2);

endmodule

//--- hdl/addr_gen_pkg.sv
package addr_gen_pkg;

  // ********************************************************
  // operand modes and result areas
  // ********************************************************
  typedef enum logic [3:0]
  {
    mode_implied_mul,
    mode_reg8,
    mode_reg16,
    mode_direct,
    mode_short,
    mode_sfr,
    mode_indirect,
    mode_based,
    mode_based_idx,
    mode_stack
  } mode_type;

  typedef enum logic [1:0]
  {
    area_none,
    area_other,
    area_hs_ram,
    area_sfr
  } area_type;

  // ********************************************************
  // request from the decoder and answer to the memory bus
  // ********************************************************
  typedef struct packed
  {
    mode_type mode;
    logic wide;
    logic [2:0] byte_reg_select_code;
    logic [1:0] pair_select_code;
    logic [7:0] imm8;
    logic [15:0] imm16;
    logic index_is_b;
    logic sfr_wide_ok;
  } request_type;

  typedef struct packed
  {
    logic [15:0] eff_addr;
    area_type area;
    logic fault;
    logic [4:0] reg_index;
    logic [15:0] operand;
  } result_type;

  // ********************************************************
  // register codes, address map, reset values
  // ********************************************************
  localparam logic [2:0] CODE_X = 3'h0;
  localparam logic [2:0] CODE_A = 3'h1;
  localparam logic [2:0] CODE_C = 3'h2;
  localparam logic [2:0] CODE_B = 3'h3;
  localparam logic [1:0] ACC_PAIR = 2'h0;
  localparam logic [1:0] POINTER_PAIR_TWO = 2'h2;
  localparam logic [1:0] BASE_PAIR = 2'h3;
  localparam logic [6:0] SHORT_TOP_BITS = 7'h7f;
  localparam logic [7:0] SHORT_SFR_LIMIT = 8'h20;
  localparam logic [15:0] SFR_BASE = 16'hff00;
  localparam logic [15:0] SFR_GAP_LO = 16'hffd0;
  localparam logic [15:0] SFR_GAP_HI = 16'hffdf;
  localparam logic [15:0] HS_RAM_LO = 16'hfe20;
  localparam logic [15:0] HS_RAM_HI = 16'hfeff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_REG_BYTES = 32;
  localparam result_type RESULT_RESET = '{16'h0000, area_none, 1'b0, 5'h00, 16'h0000};

endpackage

//--- hdl/reg_bank_mem.sv
// ********************************************************
// four banks of eight byte registers, whole bank read out
// ********************************************************
module reg_bank_mem
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic wr_wide,
  input wire logic [4:0] wr_index,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_bank,
  output logic [63:0] rd_row
);

  logic [7:0] store [addr_gen_pkg::NUM_REG_BYTES];

  // wide writes ignore index bit 0: low byte even, high byte odd
  genvar i;
  generate
    for (i = 0; i < addr_gen_pkg::NUM_REG_BYTES; i++)
    begin : g_byte
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          store[i] <= addr_gen_pkg::REG_RESET;
        else if (wr_en && wr_wide && wr_index[4:1] == 4'(i / 2))
          store[i] <= (i % 2 == 1) ? wr_data[15:8] : wr_data[7:0];
        else if (wr_en && !wr_wide && wr_index == 5'(i))
          store[i] <= wr_data[7:0];
      end
    end
  endgenerate

  // registered read of the selected bank
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rd_row <= 64'h0;
    else
      for (int b = 0; b < 8; b++)
        rd_row[b*8 +: 8] <= store[{rd_bank, 3'(b)}];
  end

endmodule

//--- sim/core_decoder_model.sv
// ********************************************************
// decoder and core register port driving the generator
// ********************************************************
module core_decoder_model
(
  input wire logic ref_clk,
  output logic req_valid,
  output addr_gen_pkg::request_type req,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [15:0] stack_ptr,
  output logic reg_wr_en,
  output logic reg_wr_wide,
  output logic [2:0] reg_wr_code,
  output logic [15:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // quiet values at time zero
  initial
  begin
    req_valid = 1'b0;
    req = '0;
    bank_select_low = 1'b0;
    bank_select_high = 1'b0;
    stack_ptr = 16'h0000;
    reg_wr_en = 1'b0;
    reg_wr_wide = 1'b0;
    reg_wr_code = 3'h0;
    reg_wr_data = 16'h0000;
  end

  // bank flags move at the falling edge only
  task automatic set_bank(input logic [1:0] b);
    @(negedge ref_clk);
    bank_select_high = b[1];
    bank_select_low = b[0];
  endtask

  // one request; fields inverted once released so stale data cannot pass
  task automatic send(input addr_gen_pkg::request_type r, input logic [15:0] sp);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = r;
    stack_ptr = sp;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req = ~r;
    stack_ptr = ~sp;
  endtask

  // one core register write, byte or pair
  task automatic write_reg(input logic wide, input logic [2:0] code, input logic [15:0] data);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_wr_wide = wide;
    reg_wr_code = code;
    reg_wr_data = data;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_wr_data = ~data;
  endtask
endmodule

//--- sim/test_operand_address_generator.sv
module test_operand_address_generator;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************
  // clock, reset, design and driver
  // ********************************************************
  logic ref_clk;
  logic nrst;
  logic req_valid;
  addr_gen_pkg::request_type req;
  logic bank_select_low;
  logic bank_select_high;
  logic [15:0] stack_ptr;
  logic reg_wr_en;
  logic reg_wr_wide;
  logic [2:0] reg_wr_code;
  logic [15:0] reg_wr_data;
  logic ans_valid;
  addr_gen_pkg::result_type ans;
  int bad_count;
  int check_count;
  logic [7:0] bank0_bytes [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf0};

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  operand_address_generator operand_address_generator_i
  (
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .stack_ptr(stack_ptr), .reg_wr_en(reg_wr_en), .reg_wr_wide(reg_wr_wide),
    .reg_wr_code(reg_wr_code), .reg_wr_data(reg_wr_data), .ans_valid(ans_valid), .ans(ans)
  );

  core_decoder_model core_decoder_model_i
  (
    .ref_clk(ref_clk), .req_valid(req_valid), .req(req),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .stack_ptr(stack_ptr), .reg_wr_en(reg_wr_en), .reg_wr_wide(reg_wr_wide),
    .reg_wr_code(reg_wr_code), .reg_wr_data(reg_wr_data)
  );

  // ********************************************************
  // shared helpers
  // ********************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic addr_gen_pkg::request_type mk(input addr_gen_pkg::mode_type m, input logic [7:0] i8,
                                                   input logic [15:0] i16);
    addr_gen_pkg::request_type r;
    r = '0;
    r.mode = m;
    r.imm8 = i8;
    r.imm16 = i16;
    return r;
  endfunction

  // send and wait, bounded, for the answer pulse
  task automatic ask(input addr_gen_pkg::request_type r, input logic [15:0] sp);
    int n;
    core_decoder_model_i.send(r, sp);
    n = 0;
    while (ans_valid !== 1'b1 && n < 4)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("answer pulse", 16'h0001, {15'h0000, ans_valid});
  endtask

  // memory answer: address, area and no fault
  task automatic mem(input addr_gen_pkg::request_type r, input logic [15:0] sp, input logic [15:0] a,
                     input addr_gen_pkg::area_type ar);
    ask(r, sp);
    chk("eff_addr", a, ans.eff_addr);
    chk("area", {14'h0000, ar}, {14'h0000, ans.area});
    chk("fault clear", 16'h0000, {15'h0000, ans.fault});
  endtask

  // refused address: fault flag only, address left open
  task automatic flt(input addr_gen_pkg::request_type r, input logic [15:0] sp);
    ask(r, sp);
    chk("fault set", 16'h0001, {15'h0000, ans.fault});
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_regs();
    addr_gen_pkg::request_type r;
    for (int p = 0; p < 4; p++)
      core_decoder_model_i.write_reg(1'b1, 3'(2 * p), {bank0_bytes[2 * p + 1], bank0_bytes[2 * p]});
    core_decoder_model_i.set_bank(2'h2);
    core_decoder_model_i.write_reg(1'b0, 3'h7, 16'h00a5);
    r = mk(addr_gen_pkg::mode_reg8, 8'h00, 16'h0000);
    r.byte_reg_select_code = 3'h7;
    ask(r, 16'h0000);
    chk("bank2 byte", 16'h00a5, {8'h00, ans.operand[7:0]});
    chk("bank2 index", 16'h0017, {11'h000, ans.reg_index});
    core_decoder_model_i.set_bank(2'h0);
    for (int c = 0; c < 8; c++)
    begin
      r.byte_reg_select_code = 3'(c);
      ask(r, 16'h0000);
      chk("byte reg", {8'h00, bank0_bytes[c]}, {8'h00, ans.operand[7:0]});
      chk("byte index", 16'(c), {11'h000, ans.reg_index});
    end
    r.mode = addr_gen_pkg::mode_reg16;
    for (int p = 0; p < 4; p++)
    begin
      r.pair_select_code = 2'(p);
      ask(r, 16'h0000);
      chk("pair reg", {bank0_bytes[2 * p + 1], bank0_bytes[2 * p]}, ans.operand);
    end
  endtask

  task automatic t_mul();
    addr_gen_pkg::request_type r;
    ask(mk(addr_gen_pkg::mode_implied_mul, 8'h00, 16'h0000), 16'h0000);
    chk("product", 16'h03a8, ans.operand);
    r = mk(addr_gen_pkg::mode_reg16, 8'h00, 16'h0000);
    r.pair_select_code = addr_gen_pkg::ACC_PAIR;
    ask(r, 16'h0000);
    chk("product in pair", 16'h03a8, ans.operand);
  endtask

  task automatic t_direct_short();
    addr_gen_pkg::request_type r;
    mem(mk(addr_gen_pkg::mode_direct, 8'h00, 16'h1234), 16'h0000, 16'h1234, addr_gen_pkg::area_other);
    mem(mk(addr_gen_pkg::mode_direct, 8'h00, 16'hfe00), 16'h0000, 16'hfe00, addr_gen_pkg::area_other);
    mem(mk(addr_gen_pkg::mode_short, 8'h20, 16'h0000), 16'h0000, 16'hfe20, addr_gen_pkg::area_hs_ram);
    mem(mk(addr_gen_pkg::mode_short, 8'hff, 16'h0000), 16'h0000, 16'hfeff, addr_gen_pkg::area_hs_ram);
    mem(mk(addr_gen_pkg::mode_short, 8'h00, 16'h0000), 16'h0000, 16'hff00, addr_gen_pkg::area_sfr);
    mem(mk(addr_gen_pkg::mode_short, 8'h1f, 16'h0000), 16'h0000, 16'hff1f, addr_gen_pkg::area_sfr);
    r = mk(addr_gen_pkg::mode_short, 8'h22, 16'h0000);
    r.wide = 1'b1;
    mem(r, 16'h0000, 16'hfe22, addr_gen_pkg::area_hs_ram);
    r.imm8 = 8'h21;
    flt(r, 16'h0000);
  endtask

  task automatic t_sfr();
    addr_gen_pkg::request_type r;
    mem(mk(addr_gen_pkg::mode_sfr, 8'h00, 16'h0000), 16'h0000, 16'hff00, addr_gen_pkg::area_sfr);
    mem(mk(addr_gen_pkg::mode_sfr, 8'hcf, 16'h0000), 16'h0000, 16'hffcf, addr_gen_pkg::area_sfr);
    mem(mk(addr_gen_pkg::mode_sfr, 8'he0, 16'h0000), 16'h0000, 16'hffe0, addr_gen_pkg::area_sfr);
    mem(mk(addr_gen_pkg::mode_sfr, 8'hff, 16'h0000), 16'h0000, 16'hffff, addr_gen_pkg::area_sfr);
    flt(mk(addr_gen_pkg::mode_sfr, 8'hd0, 16'h0000), 16'h0000);
    flt(mk(addr_gen_pkg::mode_sfr, 8'hdf, 16'h0000), 16'h0000);
    r = mk(addr_gen_pkg::mode_sfr, 8'h10, 16'h0000);
    r.wide = 1'b1;
    r.sfr_wide_ok = 1'b1;
    mem(r, 16'h0000, 16'hff10, addr_gen_pkg::area_sfr);
    r.imm8 = 8'h11;
    flt(r, 16'h0000);
    r.imm8 = 8'h12;
    r.sfr_wide_ok = 1'b0;
    flt(r, 16'h0000);
  endtask

  task automatic t_pointer();
    addr_gen_pkg::request_type r;
    r = mk(addr_gen_pkg::mode_indirect, 8'h00, 16'h0000);
    r.pair_select_code = addr_gen_pkg::POINTER_PAIR_TWO;
    mem(r, 16'h0000, 16'hbc9a, addr_gen_pkg::area_other);
    r.pair_select_code = addr_gen_pkg::BASE_PAIR;
    mem(r, 16'h0000, 16'hf0de, addr_gen_pkg::area_other);
    r.pair_select_code = addr_gen_pkg::ACC_PAIR;
    flt(r, 16'h0000);
    mem(mk(addr_gen_pkg::mode_based, 8'h22, 16'h0000), 16'h0000, 16'hf100, addr_gen_pkg::area_other);
    r = mk(addr_gen_pkg::mode_based_idx, 8'h00, 16'h0000);
    r.index_is_b = 1'b1;
    mem(r, 16'h0000, 16'hf156, addr_gen_pkg::area_other);
    r.index_is_b = 1'b0;
    mem(r, 16'h0000, 16'hf134, addr_gen_pkg::area_other);
    core_decoder_model_i.set_bank(2'h1);
    core_decoder_model_i.write_reg(1'b1, 3'h6, 16'hfff0);
    mem(mk(addr_gen_pkg::mode_based, 8'h20, 16'h0000), 16'h0000, 16'h0010, addr_gen_pkg::area_other);
    core_decoder_model_i.set_bank(2'h0);
  endtask

  task automatic t_stack();
    mem(mk(addr_gen_pkg::mode_stack, 8'h00, 16'h0000), 16'hfe80, 16'hfe80, addr_gen_pkg::area_hs_ram);
    flt(mk(addr_gen_pkg::mode_stack, 8'h00, 16'h0000), 16'hfe1f);
    flt(mk(addr_gen_pkg::mode_stack, 8'h00, 16'h0000), 16'hff00);
  endtask

  // ********************************************************
  // sequence, watchdog and verdict
  // ********************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    bad_count = 0;
    check_count = 0;
    nrst = 1'b0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    t_regs();
    t_direct_short();
    t_sfr();
    t_pointer();
    t_stack();
    t_mul();
    complete_run();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end
endmodule
